// ### src/ufm_frame_irq.sv
// Purpose: Frame timing, packet qualification and interrupt events
// Assumes: bit_tick is an asynchronous 12 MHz strobe level from a pin
// Notes:   Shared-area writes are requested here and acknowledged outside
`timescale 1ns/100ps
module ufm_frame_irq #(
	parameter bit HAS_MGMT_PIN = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic        bit_tick,
	input  wire logic        lp_req,
	input  wire logic        lp_low_speed,
	input  wire logic        lp_periodic_pending,
	input  wire logic        other_lists_on,
	input  wire logic [10:0] endpoint_max_packet_bytes,
	output logic             lp_check_fail,
	output logic             periodic_go,
	output logic             se_req,
	output logic             se_sof,
	output logic [10:0]      se_sof_data,
	input  wire logic        se_ack,
	output logic             shared_wr_req,
	output logic [15:0]      shared_wr_data,
	input  wire logic        shared_wr_done,
	input  wire logic        done_list_wr_done,
	input  wire logic        resume_signal,
	input  wire logic        remote_wake_enable,
	input  wire logic        port_connect_change,
	input  wire logic        port_resume_active,
	output logic             port_resume_clear,
	input  wire logic        hub_status_changed,
	input  wire logic        owner_handover_event,
	output logic             normal_irq,
	output logic             sys_mgmt_irq_pin
);
	// ****************************************
	// Registers
	// ****************************************
	logic [31:0]  control_r;
	logic [31:0]  irq_status_reg;
	logic [31:0]  irq_enable_reg;
	logic [31:0]  frame_length_reg;
	logic [13:0]  frame_time_left;
	logic         time_left_toggle;
	logic [15:0]  frame_count;
	logic [13:0]  periodic_begin_point;
	logic [11:0]  slow_speed_cutoff;
	logic [14:0]  budget_r;
	logic [2:0]   stuff_r;
	logic [2:0]   tick_sync_r;
	logic         tick_prev_r;
	logic [1:0]   state_prev_r;
	logic         pend_sof_r;
	logic         pend_wrap_r;
	logic         pend_overrun_r;
	logic         req_open_r;
	logic         wake_hold_r;
	ufm_pkg::ufm_wb_t wb_r;
	logic [31:0]  set_bits;
	logic         tick;
	logic         reload;
	logic [1:0]   state;
	logic         running;
	logic         suspended;
	logic         fit_ok;
	logic         enabled_any;
	logic         owner_any;

	assign state     = control_r[ufm_pkg::CTL_STATE_LO +: 2];
	assign running   = (state == ufm_pkg::ST_RUNNING);
	assign suspended = (state == ufm_pkg::ST_SUSPEND);
	// ****************************************
	// Bit-time strobe from pin
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tick_sync_r <= 3'h0;
			tick_prev_r <= 1'b0;
		end else begin
			tick_sync_r <= {tick_sync_r[1:0], bit_tick};
			if (tick_sync_r[1] == tick_sync_r[2]) begin
				tick_prev_r <= tick_sync_r[2];
			end
		end
	end
	assign tick = (tick_sync_r[1] == tick_sync_r[2]) && tick_sync_r[2]
		&& !tick_prev_r;
	// Reload at zero or on entry into running
	assign reload = running && ((tick && frame_time_left == 14'h0000)
		|| state_prev_r != ufm_pkg::ST_RUNNING);
	// ****************************************
	// Frame timing
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			frame_time_left  <= 14'h0000;
			time_left_toggle <= 1'b0;
			frame_count      <= 16'h0000;
			state_prev_r     <= ufm_pkg::ST_RESET;
		end else begin
			state_prev_r <= state;
			if (reload) begin
				frame_time_left  <= frame_length_reg[13:0];
				time_left_toggle <= frame_length_reg[ufm_pkg::FLEN_TOGGLE];
				frame_count      <= frame_count + 16'h0001;
			end else if (running && tick) begin
				frame_time_left <= frame_time_left - 14'h0001;
			end
		end
	end
	// ****************************************
	// Largest packet budget
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			budget_r <= 15'h0000;
			stuff_r  <= 3'h0;
		end else if (reload) begin
			budget_r <= frame_length_reg[ufm_pkg::FLEN_BUDGET_LO +: 15];
			stuff_r  <= 3'h0;
		end else if (running && tick) begin
			stuff_r <= (stuff_r == ufm_pkg::STUFF_LAST) ? 3'h0
				: stuff_r + 3'h1;
			if (stuff_r != ufm_pkg::STUFF_LAST && budget_r != 15'h0000) begin
				budget_r <= budget_r - 15'h0001;
			end
		end
	end
	// ****************************************
	// Transaction qualification
	// ****************************************
	always_comb begin
		if (lp_low_speed) begin
			fit_ok = frame_time_left >= {2'h0, slow_speed_cutoff};
		end else begin
			fit_ok = {1'b0, endpoint_max_packet_bytes, 3'h0} <= budget_r;
		end
	end
	assign periodic_go = running && lp_periodic_pending
		&& (frame_time_left < periodic_begin_point || !other_lists_on);
	// Requests pass only while the check holds
	assign se_req        = lp_req && running && fit_ok && !se_sof;
	assign lp_check_fail = lp_req && req_open_r && !fit_ok;
	assign se_sof        = running && frame_time_left == ufm_pkg::SOF_POINT;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			req_open_r  <= 1'b0;
			se_sof_data <= 11'h000;
		end else begin
			if (se_ack || !lp_req) begin
				req_open_r <= 1'b0;
			end else begin
				req_open_r <= 1'b1;
			end
			se_sof_data <= frame_count[ufm_pkg::SOF_BITS-1:0];
		end
	end
	// ****************************************
	// Shared-area count writeback
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wb_r           <= ufm_pkg::UFM_WB_IDLE;
			shared_wr_data <= 16'h0000;
		end else begin
			case (wb_r)
				ufm_pkg::UFM_WB_IDLE: begin
					if (reload) begin
						wb_r <= ufm_pkg::UFM_WB_BUSY;
						shared_wr_data <= frame_count + 16'h0001;
					end
				end
				default: begin
					if (shared_wr_done) begin
						wb_r <= ufm_pkg::UFM_WB_IDLE;
					end
				end
			endcase
		end
	end
	assign shared_wr_req = (wb_r == ufm_pkg::UFM_WB_BUSY);
	// Events waiting for the next count write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pend_sof_r     <= 1'b0;
			pend_wrap_r    <= 1'b0;
			pend_overrun_r <= 1'b0;
		end else begin
			if (reload) begin
				pend_sof_r <= 1'b1;
				if (frame_count[ufm_pkg::COUNT_MSB-1:0] == 15'h7FFF) begin
					pend_wrap_r <= 1'b1;
				end
				if (lp_periodic_pending) begin
					pend_overrun_r <= 1'b1;
				end
			end else if (shared_wr_done && wb_r == ufm_pkg::UFM_WB_BUSY) begin
				pend_sof_r     <= 1'b0;
				pend_wrap_r    <= 1'b0;
				pend_overrun_r <= 1'b0;
			end
		end
	end
	// ****************************************
	// Interrupt status
	// ****************************************
	assign port_resume_clear = suspended && state_prev_r != ufm_pkg::ST_SUSPEND
		&& port_resume_active;
	always_comb begin
		set_bits = 32'h0000_0000;
		if (shared_wr_done && wb_r == ufm_pkg::UFM_WB_BUSY) begin
			set_bits[ufm_pkg::IRQ_FRM_START] = pend_sof_r;
			set_bits[ufm_pkg::IRQ_WRAP]      = pend_wrap_r;
			set_bits[ufm_pkg::IRQ_OVERRUN]   = pend_overrun_r;
		end
		set_bits[ufm_pkg::IRQ_DONE_LIST] = done_list_wr_done;
		set_bits[ufm_pkg::IRQ_WAKE] = suspended && (resume_signal
			|| (remote_wake_enable && port_connect_change)
			|| port_resume_clear);
		set_bits[ufm_pkg::IRQ_HUB]   = hub_status_changed;
		set_bits[ufm_pkg::IRQ_OWNER] = owner_handover_event;
		set_bits[ufm_pkg::IRQ_FATAL] = 1'b0;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_status_reg <= 32'h0000_0000;
		end else if (reg_write && reg_addr == ufm_pkg::ADR_IRQ_STATUS) begin
			irq_status_reg <= (irq_status_reg & ~reg_wdata) | set_bits;
		end else begin
			irq_status_reg <= irq_status_reg | set_bits;
		end
	end
	// ****************************************
	// Interrupt routing
	// ****************************************
	assign enabled_any = control_r[ufm_pkg::CTL_GLOBAL_EN]
		&& |(irq_status_reg & irq_enable_reg & ~(32'h1 << ufm_pkg::IRQ_OWNER));
	assign owner_any = control_r[ufm_pkg::CTL_GLOBAL_EN]
		&& irq_status_reg[ufm_pkg::IRQ_OWNER]
		&& irq_enable_reg[ufm_pkg::IRQ_OWNER];
	// Wake request registered; drops with its status, enable or global enable bit
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wake_hold_r <= 1'b0;
		end else begin
			wake_hold_r <= irq_status_reg[ufm_pkg::IRQ_WAKE]
				&& irq_enable_reg[ufm_pkg::IRQ_WAKE]
				&& control_r[ufm_pkg::CTL_GLOBAL_EN];
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			normal_irq       <= 1'b0;
			sys_mgmt_irq_pin <= 1'b0;
		end else begin
			normal_irq <= (enabled_any || wake_hold_r)
				&& !control_r[ufm_pkg::CTL_ROUTE];
			sys_mgmt_irq_pin <= HAS_MGMT_PIN && (owner_any
				|| ((enabled_any || wake_hold_r)
				&& control_r[ufm_pkg::CTL_ROUTE]));
		end
	end
	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			control_r            <= 32'h0000_0000;
			irq_enable_reg       <= 32'h0000_0000;
			frame_length_reg     <= {1'b0, ufm_pkg::BUDGET_RST, 2'h0,
				ufm_pkg::FRM_LEN_RST};
			periodic_begin_point <= ufm_pkg::PERIODIC_RST;
			slow_speed_cutoff    <= ufm_pkg::LS_CUTOFF_RST;
		end else if (reg_write) begin
			if (reg_addr == ufm_pkg::ADR_CONTROL) begin
				control_r <= reg_wdata;
			end else if (reg_addr == ufm_pkg::ADR_IRQ_ENABLE) begin
				irq_enable_reg <= reg_wdata;
			end else if (reg_addr == ufm_pkg::ADR_FRM_LEN) begin
				frame_length_reg <= reg_wdata;
			end else if (reg_addr == ufm_pkg::ADR_PERIODIC) begin
				periodic_begin_point <= reg_wdata[13:0];
			end else if (reg_addr == ufm_pkg::ADR_LS_CUTOFF) begin
				slow_speed_cutoff <= reg_wdata[11:0];
			end
		end
	end
	// ****************************************
	// Register reads
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!reg_read) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == ufm_pkg::ADR_CONTROL) begin
			reg_rdata <= control_r;
		end else if (reg_addr == ufm_pkg::ADR_IRQ_STATUS) begin
			reg_rdata <= irq_status_reg;
		end else if (reg_addr == ufm_pkg::ADR_IRQ_ENABLE) begin
			reg_rdata <= irq_enable_reg;
		end else if (reg_addr == ufm_pkg::ADR_FRM_LEN) begin
			reg_rdata <= frame_length_reg;
		end else if (reg_addr == ufm_pkg::ADR_TIME_LEFT) begin
			reg_rdata <= {time_left_toggle, 17'h00000, frame_time_left};
		end else if (reg_addr == ufm_pkg::ADR_FRM_COUNT) begin
			reg_rdata <= {16'h0000, frame_count};
		end else if (reg_addr == ufm_pkg::ADR_PERIODIC) begin
			reg_rdata <= {18'h00000, periodic_begin_point};
		end else if (reg_addr == ufm_pkg::ADR_LS_CUTOFF) begin
			reg_rdata <= {20'h00000, slow_speed_cutoff};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// ### src/ufm_pkg.sv
// Purpose: Constants for the USB host frame management and interrupt block
// Assumes: 10 MHz system clock, 12 MHz bit-time strobe supplied as a pin
// Notes:   Registers reached over a plain address/strobe port
//
// Overview of operation
// - 16-bit frame count increments on every reload
// - SOF data field carries count bits 10:0
// - Write count to shared area after increment
// - Periodic begins below begin point or alone
// - Low speed allowed only at/above cutoff
// - Full speed allowed if size fits budget
// - Budget counter reloads at frame boundary
// - Budget decrements six of seven bit times
// - All serial engine requests pass through here
// - Check until acknowledge; flag failure
// - SOF request when time left equals one
// - Irq needs global, status and enable bits
// - Route select picks normal or management pin
// - Overrun flag after next shared count write
// - Done-list flag after done-list write completes
// - Frame start flag after next count write
// - Wake flag on resume, only when suspended
// - Suspend during port resume gives hub wake
// - Wake irq held while clock is stopped
// - Fatal fault flag never set
// - Wrap flag when count bit 15 toggles
// - Hub change flag on hub status change
// - 14-bit time left counts down, reloads
// - Reload time left on entering running state
// - Copy length toggle into time left toggle
package ufm_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADR_CONTROL    = 8'h00;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h04;
	localparam logic [7:0] ADR_IRQ_ENABLE = 8'h08;
	localparam logic [7:0] ADR_FRM_LEN    = 8'h0C;
	localparam logic [7:0] ADR_TIME_LEFT  = 8'h10;
	localparam logic [7:0] ADR_FRM_COUNT  = 8'h14;
	localparam logic [7:0] ADR_PERIODIC   = 8'h18;
	localparam logic [7:0] ADR_LS_CUTOFF  = 8'h1C;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTL_STATE_LO   = 6;
	localparam int CTL_ROUTE      = 8;
	localparam int CTL_GLOBAL_EN  = 31;
	localparam int IRQ_OVERRUN    = 0;
	localparam int IRQ_DONE_LIST  = 1;
	localparam int IRQ_FRM_START  = 2;
	localparam int IRQ_WAKE       = 3;
	localparam int IRQ_FATAL      = 4;
	localparam int IRQ_WRAP       = 5;
	localparam int IRQ_HUB        = 6;
	localparam int IRQ_OWNER      = 30;
	localparam int FLEN_TOGGLE    = 31;
	localparam int FLEN_BUDGET_LO = 16;
	localparam int SOF_BITS       = 11;
	localparam int COUNT_MSB      = 15;
	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [13:0] FRM_LEN_RST   = 14'h2EDF;
	localparam logic [14:0] BUDGET_RST    = 15'h2778;
	localparam logic [13:0] PERIODIC_RST  = 14'h0000;
	localparam logic [11:0] LS_CUTOFF_RST = 12'h628;
	localparam logic [13:0] SOF_POINT     = 14'h0001;
	localparam logic [2:0]  STUFF_LAST    = 3'h6;
	// Controller functional states
	localparam logic [1:0] ST_RESET   = 2'h0;
	localparam logic [1:0] ST_RESUME  = 2'h1;
	localparam logic [1:0] ST_RUNNING = 2'h2;
	localparam logic [1:0] ST_SUSPEND = 2'h3;
	typedef enum logic [1:0] {
		UFM_WB_IDLE,
		UFM_WB_BUSY
	} ufm_wb_t;
endpackage

// ### tb/ufm_chk.sv
// Purpose: Port-level checks for ufm_frame_irq
// Assumes: Far side answers within a few cycles
// Notes:   Attached to the design by bind
`timescale 1ns/100ps
module ufm_chk (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        lp_req,
	input wire logic        lp_check_fail,
	input wire logic        se_req,
	input wire logic        se_sof,
	input wire logic [10:0] se_sof_data,
	input wire logic        shared_wr_req,
	input wire logic [15:0] shared_wr_data,
	input wire logic        shared_wr_done,
	input wire logic        port_resume_active,
	input wire logic        port_resume_clear
);
	// ****************************************
	// Last written count
	// ****************************************
	logic [15:0] last_r;
	always_ff @(posedge clock) begin
		if (!rst_n)
			last_r <= 16'h0000;
		else if (shared_wr_req && shared_wr_done)
			last_r <= shared_wr_data;
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence sof_end;
		$fell(se_sof);
	endsequence
	sequence wr_start;
		##[0:8] shared_wr_req;
	endsequence
	a_count_step: assert property (
		$rose(shared_wr_req) |-> shared_wr_data == last_r + 16'h0001)
		else $error("Count write did not step by one");
	a_write_hold: assert property (
		shared_wr_req && !shared_wr_done |=>
		shared_wr_req && $stable(shared_wr_data))
		else $error("Count write dropped early");
	a_sof_data: assert property (
		se_sof |-> se_sof_data == shared_wr_data[10:0])
		else $error("Token data differs from count");
	a_sof_then_wr: assert property (
		sof_end |-> wr_start)
		else $error("No count write after token");
	a_fail_blocks: assert property (
		lp_check_fail |-> !se_req)
		else $error("Request passed a failed check");
	a_req_from_lp: assert property (
		se_req |-> lp_req)
		else $error("Engine request without source");
	a_fail_from_lp: assert property (
		lp_check_fail |-> lp_req)
		else $error("Check fail without request");
	a_resume_clr: assert property (
		port_resume_clear |-> port_resume_active)
		else $error("Port resume cleared without cause");
endmodule
bind ufm_frame_irq ufm_chk u_chk (
	.clock(clock), .rst_n(rst_n), .lp_req(lp_req),
	.lp_check_fail(lp_check_fail), .se_req(se_req), .se_sof(se_sof),
	.se_sof_data(se_sof_data), .shared_wr_req(shared_wr_req),
	.shared_wr_data(shared_wr_data), .shared_wr_done(shared_wr_done),
	.port_resume_active(port_resume_active),
	.port_resume_clear(port_resume_clear));

// ### tb/ufm_far_model.sv
// Purpose: Serial engine and shared memory writer model
// Assumes: Requests stay up until answered
// Notes:   slow stretches both answers
`timescale 1ns/100ps
module ufm_far_model (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic slow,
	input  wire logic se_req,
	input  wire logic shared_wr_req,
	output logic      se_ack,
	output logic      shared_wr_done
);
	logic [2:0] se_cnt_r;
	logic [2:0] wr_cnt_r;
	// ****************************************
	// Answer pulses
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_n || !se_req || se_ack) begin
			se_cnt_r <= 3'h0;
			se_ack   <= 1'b0;
		end else begin
			se_cnt_r <= se_cnt_r + 3'h1;
			se_ack   <= se_cnt_r == (slow ? 3'h5 : 3'h0);
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n || !shared_wr_req || shared_wr_done) begin
			wr_cnt_r       <= 3'h0;
			shared_wr_done <= 1'b0;
		end else begin
			wr_cnt_r       <= wr_cnt_r + 3'h1;
			shared_wr_done <= wr_cnt_r == (slow ? 3'h4 : 3'h1);
		end
	end
endmodule

// ### tb/tb_ufm_frame_irq.sv
// Purpose: Self-checking bench for ufm_frame_irq
// Assumes: Far side model answers engine and count writes
// Notes:   Short frame length keeps the run brief
`timescale 1ns/100ps
module tb_ufm_frame_irq;
	logic        clock, rst_n, bit_tick, slow, reg_write, reg_read;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv, c;
	logic        lp_req, lp_ls, fail, sreq, sof, ack, wreq, wdone;
	logic [10:0] ep_bytes, sof_data;
	logic [15:0] wdata;
	logic        done_wr, res_sig, port_res, port_clr, hub_chg;
	logic        normal_irq, mgmt_irq, pgo, per_pend, others;
	int          bad_count, compares, cycles;
	ufm_frame_irq dut_u (.clock(clock), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .bit_tick(bit_tick),
		.lp_req(lp_req), .lp_low_speed(lp_ls),
		.lp_periodic_pending(per_pend),
		.other_lists_on(others), .endpoint_max_packet_bytes(ep_bytes),
		.lp_check_fail(fail), .periodic_go(pgo), .se_req(sreq),
		.se_sof(sof), .se_sof_data(sof_data), .se_ack(ack),
		.shared_wr_req(wreq), .shared_wr_data(wdata),
		.shared_wr_done(wdone), .done_list_wr_done(done_wr),
		.resume_signal(res_sig), .remote_wake_enable(1'b0),
		.port_connect_change(1'b0), .port_resume_active(port_res),
		.port_resume_clear(port_clr), .hub_status_changed(hub_chg),
		.owner_handover_event(1'b0), .normal_irq(normal_irq),
		.sys_mgmt_irq_pin(mgmt_irq));
	ufm_far_model far_u (.clock(clock), .rst_n(rst_n), .slow(slow),
		.se_req(sreq), .shared_wr_req(wreq), .se_ack(ack),
		.shared_wr_done(wdone));
	// ****************************************
	// Clocks and timeout
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		bit_tick = 1'b0;
		forever #41.7 bit_tick = ~bit_tick;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#10 rv = reg_rdata;
	endtask
	task automatic wait_fr;
		logic seen;
		seen = 1'b0;
		repeat (400) begin
			@(negedge clock);
			if (wreq === 1'b1 && wdone === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
		cmp("frame write", 32'h1, {31'h0, seen});
	endtask
	// Mask order: resume, hub change, done list
	task automatic pulse(logic [2:0] m);
		@(posedge clock);
		{res_sig, hub_chg, done_wr} <= m;
		@(posedge clock);
		{res_sig, hub_chg, done_wr} <= 3'h0;
	endtask
	task automatic lp_try(logic ls, logic [10:0] sz, logic ea, logic ef);
		logic a, f;
		a = 1'b0;
		f = 1'b0;
		@(posedge clock);
		lp_req <= 1'b1;
		lp_ls <= ls;
		ep_bytes <= sz;
		repeat (30) begin
			@(negedge clock);
			if (fail === 1'b1)
				f = 1'b1;
			if (ack === 1'b1) begin
				a = 1'b1;
				break;
			end
		end
		@(posedge clock);
		lp_req <= 1'b0;
		cmp("engine ack", ea, a);
		cmp("check fail", ef, f);
	endtask
	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_frame;
		rd(ufm_pkg::ADR_FRM_LEN);
		cmp("len reset", {1'b0, ufm_pkg::BUDGET_RST, 2'h0,
			ufm_pkg::FRM_LEN_RST}, rv);
		rd(8'hFC);
		cmp("unmapped", 32'h0, rv);
		wr(ufm_pkg::ADR_FRM_LEN, {1'b1, 15'h0100, 2'h0, 14'h0040});
		wr(ufm_pkg::ADR_CONTROL, 32'h00000080);
		wait_fr();
		rd(ufm_pkg::ADR_FRM_COUNT);
		c = {16'h0, rv[15:0] + 16'h1};
		wait_fr();
		rd(ufm_pkg::ADR_FRM_COUNT);
		cmp("count step", c, {16'h0, rv[15:0]});
		rd(ufm_pkg::ADR_TIME_LEFT);
		cmp("toggle", 32'h1, rv >> 31);
		cmp("time left", 32'h1, rv[13:0] <= 14'h0040);
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("frame start", 32'h1, rv[ufm_pkg::IRQ_FRM_START]);
		cmp("overrun", 32'h0, rv[ufm_pkg::IRQ_OVERRUN]);
	endtask
	task automatic t_periodic;
		@(posedge clock);
		per_pend <= 1'b1;
		@(negedge clock);
		cmp("periodic alone", 32'h1, pgo);
		@(posedge clock);
		others <= 1'b1;
		@(negedge clock);
		cmp("periodic early", 32'h0, pgo);
		wr(ufm_pkg::ADR_PERIODIC, 32'h00003FFF);
		@(negedge clock);
		cmp("periodic late", 32'h1, pgo);
		wait_fr();
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("overrun set", 32'h1, rv[ufm_pkg::IRQ_OVERRUN]);
		@(posedge clock);
		per_pend <= 1'b0;
		others <= 1'b0;
	endtask
	task automatic t_irq;
		wr(ufm_pkg::ADR_IRQ_STATUS, 32'hFFFFFFFF);
		wr(ufm_pkg::ADR_IRQ_ENABLE, 32'h1 << ufm_pkg::IRQ_FRM_START);
		wr(ufm_pkg::ADR_CONTROL, 32'h80000080);
		wait_fr();
		repeat (4) @(negedge clock);
		cmp("normal irq", 32'h1, normal_irq);
		cmp("mgmt irq", 32'h0, mgmt_irq);
		wr(ufm_pkg::ADR_CONTROL, 32'h80000180);
		repeat (3) @(negedge clock);
		cmp("normal irq", 32'h0, normal_irq);
		cmp("mgmt irq", 32'h1, mgmt_irq);
		wr(ufm_pkg::ADR_CONTROL, 32'h00000080);
		repeat (3) @(negedge clock);
		cmp("irq off", 32'h0, normal_irq | mgmt_irq);
	endtask
	task automatic t_events;
		pulse(3'h1);
		pulse(3'h2);
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("done list", 32'h1, rv[ufm_pkg::IRQ_DONE_LIST]);
		cmp("hub change", 32'h1, rv[ufm_pkg::IRQ_HUB]);
		cmp("fatal", 32'h0, rv[ufm_pkg::IRQ_FATAL]);
		wr(ufm_pkg::ADR_IRQ_STATUS, 32'h1 << ufm_pkg::IRQ_DONE_LIST);
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("done clear", 32'h0, rv[ufm_pkg::IRQ_DONE_LIST]);
		cmp("hub kept", 32'h1, rv[ufm_pkg::IRQ_HUB]);
	endtask
	task automatic t_lp;
		wr(ufm_pkg::ADR_LS_CUTOFF, 32'h00000FFF);
		lp_try(1'b1, 11'h001, 1'b0, 1'b1);
		wr(ufm_pkg::ADR_LS_CUTOFF, 32'h0);
		lp_try(1'b1, 11'h001, 1'b1, 1'b0);
		lp_try(1'b0, 11'h7FF, 1'b0, 1'b1);
		@(posedge clock);
		slow <= 1'b1;
		lp_try(1'b0, 11'h001, 1'b1, 1'b0);
	endtask
	task automatic t_wake;
		logic f;
		f = 1'b0;
		pulse(3'h4);
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("wake running", 32'h0, rv[ufm_pkg::IRQ_WAKE]);
		wr(ufm_pkg::ADR_IRQ_ENABLE, 32'h1 << ufm_pkg::IRQ_WAKE);
		@(posedge clock);
		port_res <= 1'b1;
		wr(ufm_pkg::ADR_CONTROL, 32'h800000C0);
		repeat (5) begin
			@(negedge clock);
			if (port_clr === 1'b1)
				f = 1'b1;
		end
		cmp("port clear", 32'h1, f);
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("hub wake", 32'h1, rv[ufm_pkg::IRQ_WAKE]);
		cmp("wake irq", 32'h1, normal_irq);
		@(posedge clock);
		port_res <= 1'b0;
		wr(ufm_pkg::ADR_IRQ_STATUS, 32'h1 << ufm_pkg::IRQ_WAKE);
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("wake clear", 32'h0, rv[ufm_pkg::IRQ_WAKE]);
		repeat (2) @(negedge clock);
		cmp("wake irq off", 32'h0, normal_irq);
		pulse(3'h4);
		rd(ufm_pkg::ADR_IRQ_STATUS);
		cmp("wake suspend", 32'h1, rv[ufm_pkg::IRQ_WAKE]);
	endtask
	initial begin
		{rst_n, slow, reg_write, reg_read, lp_req, lp_ls} = 6'h00;
		{done_wr, res_sig, port_res, hub_chg, per_pend, others} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		ep_bytes = 11'h000;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_frame();
		t_periodic();
		t_irq();
		t_events();
		t_lp();
		t_wake();
		print_verdict();
	end
endmodule
